// ===== logic/sync_serial_regs.vh
// register map, field positions and constants of the clocked serial channel
`ifndef SYNC_SERIAL_REGS_VH
`define SYNC_SERIAL_REGS_VH

`define ADDR_MODE        8'h00
`define ADDR_BAUD        8'h04
`define ADDR_CTRL1       8'h08
`define ADDR_TXBUF       8'h0c
`define ADDR_RXBUF       8'h10

`define MODE_W           16
`define MODE_RST         16'h0000
`define MODE_SEL_HI      2
`define MODE_SEL_LO      0
`define MODE_CLK_SOURCE_SELECT       3
`define MODE_PRE_HI      5
`define MODE_PRE_LO      4
`define MODE_CLOCK_POLARITY       6
`define MODE_MSBF        7
`define MODE_INV         8
`define MODE_FLOW_EN     9
`define MODE_FLOW_RTS    10
`define MODE_CONT_RX     11
`define MODE_TXIRQ_SEL   12
`define MODE_CLK_PIN_SEL 13
`define MODE_CLK_TWO_PIN 14
`define MODE_CTS_SEP     15

`define CTRL1_TX_EN      0
`define CTRL1_TX_EMPTY   1
`define CTRL1_RX_EN      2
`define CTRL1_RX_FULL    3
`define CTRL1_SHIFT_IDLE 4
`define CTRL1_OVERRUN    5
`define RXBUF_OVERRUN    8

`define SYNC_MODE        3'b001
`define BAUD_RST         8'h00
`define BYTE_RST         8'h00
`define CNT_RST          4'h0
`define LAST_BIT         4'h7
`define OVR_BIT          4'h6
`define CNT_ONE          4'h1

`define PRE_DIV1         2'b00
`define PRE_DIV2         2'b01
`define PRE_DIV8         2'b10
`define PRE_DIV32        2'b11
`define PRE_MAX1         5'h00
`define PRE_MAX2         5'h01
`define PRE_MAX8         5'h07
`define PRE_MAX32        5'h1f
`define PRE_ONE          5'h01
`define DIV_ONE          8'h01

`endif

// ===== logic/baud_tick.v
// prescaler and baud divider producing half-period ticks of the transfer clock
`default_nettype none
`timescale 1ns/1ps
`include "sync_serial_regs.vh"

module baud_tick (
	input  wire       clock,
	input  wire       rst,
	input  wire       run,
	input  wire [1:0] prescale_sel,
	input  wire [7:0] baud_divider,
	output wire       tick
);

	reg [4:0] pre_r;
	reg [7:0] div_r;
	wire      pre_end;
	wire      div_end;

	function [4:0] pre_max;
		input [1:0] sel;
		begin
			case (sel)
				`PRE_DIV1: pre_max = `PRE_MAX1;
				`PRE_DIV2: pre_max = `PRE_MAX2;
				`PRE_DIV8: pre_max = `PRE_MAX8;
				default:   pre_max = `PRE_MAX32;
			endcase
		end
	endfunction

	assign pre_end = (pre_r == pre_max(prescale_sel));
	assign div_end = (div_r == baud_divider);
	// one tick per (prescale)*(n+1) clocks: a full clock period is twice that
	assign tick    = run & pre_end & div_end;

	// counters held at zero while idle so the first half period is full length
	always @(posedge clock) begin
		if (rst || !run) begin
			pre_r <= 5'h00;
			div_r <= `BAUD_RST;
		end else if (pre_end) begin
			pre_r <= 5'h00;
			div_r <= div_end ? `BAUD_RST : div_r + `DIV_ONE;
		end else begin
			pre_r <= pre_r + `PRE_ONE;
		end
	end

endmodule
`default_nettype wire

// ===== logic/sync_serial_channel.v
// one channel of the serial unit in clocked synchronous mode, with an APB slave
//
// Chosen here: the register offsets and register access over APB.
`default_nettype none
`timescale 1ns/1ps
`include "sync_serial_regs.vh"

module sync_serial_channel #(
	parameter CHANNEL = 0
) (
	input  wire        clock,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output wire [31:0] prdata,
	input  wire        clk_pin_i,
	output wire        clk_pin_o,
	output wire        clk_pin_oe,
	output wire        clk_pin2_o,
	output wire        clk_pin2_oe,
	output wire        serial_data_out,
	input  wire        serial_data_in,
	input  wire        cts_rts_pin_i,
	output wire        cts_rts_pin_o,
	output wire        cts_rts_pin_oe,
	input  wire        cts_sep_n,
	output wire        tx_irq_req,
	output wire        rx_irq_req
);

	reg [`MODE_W-1:0] mode_r;
	reg [7:0]         baud_r;
	reg               tx_en_r;
	reg               rx_en_r;
	reg [7:0]         txbuf_r;
	reg               tx_empty_r;
	reg [7:0]         rxbuf_r;
	reg               rx_full_r;
	reg               ovr_r;
	reg               frame_ovr_r;
	reg               busy_r;
	reg               rx_act_r;
	reg [7:0]         tsh_r;
	reg [7:0]         rsh_r;
	reg [3:0]         cnt_r;
	reg               clk_r;
	reg               clk_prev_r;
	reg               txd_r;
	reg               rts_r;
	reg               tx_irq_r;
	reg               rx_irq_r;
	reg [31:0]        prdata_r;

	wire mode_ok;
	wire ext_clk;
	wire polarity;
	wire msb_first;
	wire inv;
	wire idle_lvl;
	wire cts_mode;
	wire cts_in;
	wire tick;
	wire lead_edge;
	wire trail_edge;
	wire start;
	wire frame_done;
	wire setup;
	wire access;
	wire wr;
	wire rd_rx;
	wire rx_in;
	wire two_pin;
	wire sep_pins;

	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a == `ADDR_MODE) || (a == `ADDR_BAUD) || (a == `ADDR_CTRL1) ||
				(a == `ADDR_TXBUF) || (a == `ADDR_RXBUF);
		end
	endfunction

	assign mode_ok   = (mode_r[`MODE_SEL_HI:`MODE_SEL_LO] == `SYNC_MODE);
	assign ext_clk   = mode_r[`MODE_CLK_SOURCE_SELECT];
	assign polarity  = mode_r[`MODE_CLOCK_POLARITY];
	assign msb_first = mode_r[`MODE_MSBF];
	assign inv       = mode_r[`MODE_INV];
	// polarity 0 idles high so the first edge of a frame is the falling drive edge
	assign idle_lvl  = ~polarity;
	assign sep_pins  = (CHANNEL == 0) && mode_r[`MODE_CTS_SEP];
	assign two_pin   = (CHANNEL == 1) && mode_r[`MODE_CLK_TWO_PIN] && !ext_clk;
	assign cts_mode  = mode_r[`MODE_FLOW_EN] && !mode_r[`MODE_FLOW_RTS];
	assign cts_in    = sep_pins ? cts_sep_n : cts_rts_pin_i;

	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign wr     = access && pwrite && addr_ok(paddr);
	assign rd_rx  = access && !pwrite && (paddr == `ADDR_RXBUF);

	baud_tick u_baud (
		.clock        (clock),
		.rst          (rst),
		.run          (busy_r && !ext_clk),
		.prescale_sel (mode_r[`MODE_PRE_HI:`MODE_PRE_LO]),
		.baud_divider (baud_r),
		.tick         (tick)
	);

	// external clock pin is taken as synchronous, so a plain previous-value edge detect
	assign lead_edge  = busy_r && (ext_clk ? (clk_prev_r == idle_lvl && clk_pin_i != idle_lvl)
		: (tick && clk_r == idle_lvl));
	assign trail_edge = busy_r && (ext_clk ? (clk_prev_r != idle_lvl && clk_pin_i == idle_lvl)
		: (tick && clk_r != idle_lvl));
	assign frame_done = trail_edge && (cnt_r == `LAST_BIT);

	// an external clock must rest at its idle level before a frame may start
	assign start = mode_ok && !busy_r && tx_en_r && !tx_empty_r && (!cts_mode || !cts_in)
		&& (!ext_clk || clk_pin_i == idle_lvl);

	assign rx_in = serial_data_in ^ inv;

	// bus side: no wait states, read data captured in the setup cycle
	assign pready  = penable;
	assign pslverr = access && !addr_ok(paddr);
	assign prdata  = prdata_r;

	always @(posedge clock) begin
		if (rst) begin
			prdata_r <= 32'h00000000;
		end else if (setup) begin
			case (paddr)
				`ADDR_MODE:  prdata_r <= {16'h0000, mode_r};
				`ADDR_BAUD:  prdata_r <= {24'h000000, baud_r};
				`ADDR_CTRL1: prdata_r <= {26'h0000000, ovr_r, !busy_r, rx_full_r,
					rx_en_r, tx_empty_r, tx_en_r};
				`ADDR_RXBUF: prdata_r <= {23'h000000, ovr_r, rxbuf_r};
				default:     prdata_r <= 32'h00000000;
			endcase
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			mode_r  <= `MODE_RST;
			baud_r  <= `BAUD_RST;
			tx_en_r <= 1'b0;
			rx_en_r <= 1'b0;
			txbuf_r <= `BYTE_RST;
		end else if (wr) begin
			case (paddr)
				`ADDR_MODE:  mode_r <= pwdata[`MODE_W-1:0];
				`ADDR_BAUD:  baud_r <= pwdata[7:0];
				`ADDR_CTRL1: begin
					tx_en_r <= pwdata[`CTRL1_TX_EN];
					rx_en_r <= pwdata[`CTRL1_RX_EN];
				end
				`ADDR_TXBUF: txbuf_r <= pwdata[7:0];
				default:     baud_r <= baud_r;
			endcase
		end
	end

	// buffer flags: frame_done setting rx_full_r wins over a read in the same cycle; a TXBUF write clearing tx_empty_r wins over start
	always @(posedge clock) begin
		if (rst) begin
			tx_empty_r <= 1'b1;
		end else if (wr && paddr == `ADDR_TXBUF) begin
			tx_empty_r <= 1'b0;
		end else if (rd_rx && mode_r[`MODE_CONT_RX] && !start) begin
			// old buffer contents are reused as dummy data for the next frame
			tx_empty_r <= 1'b0;
		end else if (start) begin
			tx_empty_r <= 1'b1;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			rx_full_r <= 1'b0;
			rxbuf_r   <= `BYTE_RST;
		end else if (frame_done && rx_act_r && !frame_ovr_r) begin
			rx_full_r <= 1'b1;
			rxbuf_r   <= msb_first ? {rsh_r[6:0], rx_in} : {rx_in, rsh_r[7:1]};
		end else if (rd_rx || !rx_en_r) begin
			rx_full_r <= 1'b0;
		end
	end

	// overrun stays until reception is disabled or the mode is left
	always @(posedge clock) begin
		if (rst) begin
			ovr_r <= 1'b0;
		end else if (trail_edge && cnt_r == `OVR_BIT && rx_act_r && rx_full_r) begin
			ovr_r <= 1'b1;
		end else if (!rx_en_r || !mode_ok) begin
			ovr_r <= 1'b0;
		end
	end

	// shift engine
	always @(posedge clock) begin
		if (rst) begin
			busy_r      <= 1'b0;
			rx_act_r    <= 1'b0;
			frame_ovr_r <= 1'b0;
			tsh_r       <= `BYTE_RST;
			rsh_r       <= `BYTE_RST;
			cnt_r       <= `CNT_RST;
			clk_r       <= 1'b1;
			txd_r       <= 1'b1;
		end else if (!mode_ok) begin
			busy_r   <= 1'b0;
			rx_act_r <= 1'b0;
			clk_r    <= idle_lvl;
			txd_r    <= 1'b1;
		end else if (start) begin
			busy_r      <= 1'b1;
			rx_act_r    <= rx_en_r;
			frame_ovr_r <= 1'b0;
			tsh_r       <= txbuf_r;
			cnt_r       <= `CNT_RST;
			clk_r       <= idle_lvl;
		end else begin
			if (tick) begin
				clk_r <= ~clk_r;
			end else if (!busy_r) begin
				clk_r <= idle_lvl;
			end
			if (lead_edge) begin
				txd_r <= (msb_first ? tsh_r[7] : tsh_r[0]) ^ inv;
				tsh_r <= msb_first ? {tsh_r[6:0], 1'b0} : {1'b0, tsh_r[7:1]};
			end
			if (trail_edge) begin
				rsh_r <= msb_first ? {rsh_r[6:0], rx_in} : {rx_in, rsh_r[7:1]};
				cnt_r <= cnt_r + `CNT_ONE;
				if (cnt_r == `OVR_BIT && rx_act_r && rx_full_r) begin
					frame_ovr_r <= 1'b1;
				end
			end
			if (frame_done) begin
				busy_r   <= 1'b0;
				rx_act_r <= 1'b0;
			end
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			clk_prev_r <= 1'b1;
		end else begin
			clk_prev_r <= clk_pin_i;
		end
	end

	// request-to-send low while a receive buffer slot is free
	always @(posedge clock) begin
		if (rst) begin
			rts_r <= 1'b1;
		end else begin
			rts_r <= !(mode_ok && rx_en_r && !rx_full_r);
		end
	end

	// one-cycle event pulses; the pending flag itself lives outside this block
	always @(posedge clock) begin
		if (rst) begin
			tx_irq_r <= 1'b0;
			rx_irq_r <= 1'b0;
		end else begin
			tx_irq_r <= mode_r[`MODE_TXIRQ_SEL] ? frame_done : start;
			rx_irq_r <= frame_done && rx_act_r && !frame_ovr_r;
		end
	end

	assign tx_irq_req      = tx_irq_r;
	assign rx_irq_req      = rx_irq_r;
	assign serial_data_out = txd_r;

	// the second clock pin exists only on channel 1 with internal clock
	assign clk_pin_o   = clk_r;
	assign clk_pin_oe  = mode_ok && !ext_clk && !(two_pin && mode_r[`MODE_CLK_PIN_SEL]);
	assign clk_pin2_o  = clk_r;
	assign clk_pin2_oe = mode_ok && two_pin && mode_r[`MODE_CLK_PIN_SEL];

	// shared pin carries request-to-send when selected or when the input is separated
	assign cts_rts_pin_o  = rts_r;
	assign cts_rts_pin_oe = mode_ok && mode_r[`MODE_FLOW_EN]
		&& (mode_r[`MODE_FLOW_RTS] || sep_pins);

endmodule
`default_nettype wire

// ===== tb/serial_port_checker_asserts.sv
// port-level assertions for the clocked serial channel
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker #(parameter CHANNEL = 0) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        clk_pin_o,
	input wire logic        clk_pin_oe,
	input wire logic        clk_pin2_oe,
	input wire logic        serial_data_out,
	input wire logic        cts_rts_pin_o,
	input wire logic        tx_irq_req,
	input wire logic        rx_irq_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_ready_follows:
		assert property (pready == penable) else $error("pready differs");
	chk_err_in_access:
		assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	chk_rdata_holds:
		assert property (!psel |=> $stable(prdata)) else $error("prdata moved while idle");
	chk_reset_idle:
		assert property (disable iff (1'b0) rst |=> serial_data_out && clk_pin_o
			&& !clk_pin_oe && cts_rts_pin_o && !tx_irq_req && !rx_irq_req)
			else $error("outputs not idle after reset");
	chk_tx_irq_gap:
		assert property (tx_irq_req |=> !tx_irq_req [*8]) else $error("tx irq too close");
	chk_rx_irq_gap:
		assert property (rx_irq_req |=> !rx_irq_req [*8]) else $error("rx irq too close");
	chk_data_on_edge:
		assert property (!$past(rst) && clk_pin_oe && $past(clk_pin_oe)
			&& $changed(serial_data_out) |-> $changed(clk_pin_o))
			else $error("data moved without clock edge");
	chk_pin2_unused:
		assert property (CHANNEL != 1 |-> !clk_pin2_oe) else $error("second clock pin driven");
endmodule
bind sync_serial_channel serial_port_checker #(.CHANNEL(CHANNEL)) chk_u (.clock, .rst, .psel,
	.penable, .pready, .pslverr, .prdata, .clk_pin_o, .clk_pin_oe, .clk_pin2_oe,
	.serial_data_out, .cts_rts_pin_o, .tx_irq_req, .rx_irq_req);
`default_nettype wire

// ===== tb/serial_peer.sv
// far-end peer: sends a byte lsb first and captures the device's bits
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input  wire logic clock,
	input  wire logic sck,
	input  wire logic pol,
	input  wire logic dev_data,
	output wire logic sd,
	output var  logic ext_clk
);
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] rx = 8'h00;
	logic [3:0] cnt = 4'h0;
	logic [3:0] idx = 4'h0;
	initial ext_clk = 1'b1;
	// spent byte shows the inverse of its last bit, never a stale copy
	assign sd = idx[3] ? ~tx_byte[7] : tx_byte[idx[2:0]];
	always @(sck) begin
		if (sck ^ pol) begin
			rx <= {dev_data, rx[7:1]};
			cnt <= cnt + 4'h1;
		end else begin
			idx <= cnt;
		end
	end
	task automatic load(input logic [7:0] b);
		ext_clk <= ~pol;
		// a level change on the clock line would count as a bit; let it pass first
		repeat (2) @(posedge clock);
		tx_byte = b;
		cnt = 4'h0;
		idx = 4'h0;
	endtask
	// slow enough that the device's edge detection keeps up
	task automatic pulses();
		repeat (16) begin
			repeat (6) @(posedge clock);
			ext_clk <= ~ext_clk;
		end
	endtask
endmodule
`default_nettype wire

// ===== tb/clock_sync_serial_channel_tb_top.sv
// self-checking bench for the clocked serial channel
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.vh"
`define CHK(what, got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end
module clock_sync_serial_channel_tb_top;
	logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        cts_n = 1'b0, pol = 1'b0, sck_q = 1'b0, early = 1'b0, err;
	logic        cts_sep_n = 1'b1;
	logic [7:0]  paddr = 8'h00, per_cnt = 8'h00, last_per = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [47:0] r;
	int          rise_n = 0, rx_n = 0, n0, num_errors = 0, n_compared = 0;
	wire         pready, pslverr, clk_pin_o, clk_pin_oe, serial_data_out, sd, ext_clk;
	wire         tx_irq_req, rx_irq_req, rts_pin, rts_oe;
	wire [31:0]  prdata;
	wire         sck = clk_pin_oe ? clk_pin_o : ext_clk;
	// {mode, divider, device rx, peer rx, clock period}; peer sends c1, device 35
	logic [47:0] rows [6] = '{48'h0001_00c1_3502, 48'h0051_02c1_350c, 48'h00a1_0083_ac10,
		48'h0131_003e_ca40, 48'h11c1_017c_5304, 48'h0009_00c1_350c};
	sync_serial_channel dut_u (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .clk_pin_i(ext_clk), .clk_pin_o, .clk_pin_oe,
		.clk_pin2_o(), .clk_pin2_oe(), .serial_data_out, .serial_data_in(sd),
		.cts_rts_pin_i(cts_n), .cts_rts_pin_o(rts_pin), .cts_rts_pin_oe(rts_oe), .cts_sep_n,
		.tx_irq_req, .rx_irq_req);
	serial_peer peer_u (.clock, .sck, .pol, .dev_data(serial_data_out), .sd, .ext_clk);
	always #50 clock = ~clock;
	always @(posedge clock) begin
		sck_q <= sck;
		per_cnt <= per_cnt + 8'h01;
		if (sck && !sck_q) begin
			rise_n <= rise_n + 1;
			last_per <= per_cnt;
			per_cnt <= 8'h01;
		end
		if (tx_irq_req && rise_n < 4) early <= 1'b1;
		if (rx_irq_req) rx_n <= rx_n + 1;
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input logic ext);
		// loaded only now: a mode write moves the clock line a cycle late
		peer_u.load(8'hc1);
		rise_n = 0;
		early = 1'b0;
		n0 = rx_n;
		apb(1'b1, `ADDR_TXBUF, 32'h35);
		if (ext) peer_u.pulses();
	endtask
	task automatic wait_rx(input int lim);
		repeat (lim) if (rx_n == n0) @(posedge clock);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			r = rows[i];
			apb(1'b1, `ADDR_MODE, {16'h0, r[47:32]});
			pol = r[38];
			apb(1'b1, `ADDR_BAUD, {24'h0, r[31:24]});
			apb(1'b1, `ADDR_CTRL1, 32'h5);
			send(r[35]);
			wait_rx(3000);
			`CHK("rx irq", rx_n, n0 + 1)
			apb(1'b0, `ADDR_RXBUF, 32'h0);
			`CHK("device rx", rd[7:0], r[23:16])
			`CHK("peer rx", peer_u.rx, r[15:8])
			`CHK("clock pulses", rise_n, 8)
			`CHK("clock period", last_per, r[7:0])
			`CHK("tx irq early", early, ~r[44])
		end
		// a reset in mid-run must bring the pins back to idle
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		`CHK("data idle", serial_data_out, 1'b1)
		apb(1'b0, `ADDR_CTRL1, 32'h0);
		`CHK("ctrl1 reset", rd[3:0], 4'h2)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", {err, rd}, {1'b1, 32'h0})
		apb(1'b1, `ADDR_MODE, 32'h201);
		apb(1'b1, `ADDR_CTRL1, 32'h5);
		pol = 1'b0;
		cts_n <= 1'b1;
		send(1'b0);
		wait_rx(40);
		`CHK("cts hold", rise_n, 0)
		cts_n <= 1'b0;
		wait_rx(3000);
		`CHK("cts go", rx_n, n0 + 1)
		// second frame lands on an unread buffer
		send(1'b0);
		wait_rx(60);
		`CHK("no rx irq", rx_n, n0)
		apb(1'b0, `ADDR_CTRL1, 32'h0);
		`CHK("overrun", rd[5], 1'b1)
		apb(1'b1, `ADDR_MODE, 32'h801);
		peer_u.load(8'hc1);
		n0 = rx_n;
		apb(1'b0, `ADDR_RXBUF, 32'h0);
		wait_rx(3000);
		`CHK("cont rx", rx_n, n0 + 1)
		`CHK("dummy", peer_u.rx, 8'h35)
		// request-to-send follows the free receive slot
		apb(1'b1, `ADDR_MODE, 32'h601);
		repeat (2) @(posedge clock);
		`CHK("rts full", {rts_oe, rts_pin}, 2'b11)
		apb(1'b0, `ADDR_RXBUF, 32'h0);
		repeat (2) @(posedge clock);
		`CHK("rts free", {rts_oe, rts_pin}, 2'b10)
		// separated clear-to-send gates the start; the shared pin turns output
		apb(1'b1, `ADDR_MODE, 32'h8201);
		cts_sep_n <= 1'b1;
		send(1'b0);
		wait_rx(40);
		`CHK("sep cts hold", {rts_oe, rise_n[3:0]}, 5'h10)
		cts_sep_n <= 1'b0;
		wait_rx(3000);
		`CHK("sep cts go", rx_n, n0 + 1)
		print_verdict();
	end
endmodule
`default_nettype wire
